// [src/cme_device.sv]
// Purpose: CAM table with match port and 16-bit control port
// Assumes: link pins synchronous to clk_sys
// Notes:   table and queue searched in one cycle, answer delayed to the match time
`timescale 1ns/10ps
module cme_device
  import cme_pkg::*;
#(
  parameter int INIT_CYCLES = cme_pkg::INIT_CYC
)(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic clkEn,
  // link
  cme_link_if.dev   link
);
  import cme_pkg::*;

  typedef struct packed {
    logic [CAM_DEPTH-1:0][CAM_W-1:0]   tbl;
    logic [CAM_DEPTH-1:0]              vld;
    logic [QUEUE_DEPTH-1:0][CAM_W-1:0] que;
    logic [QCNT_W-1:0]                 qCnt;
    logic [CNT_W-1:0]                  cnt;
    logic [3:0][CTL_W-1:0]             io;
    logic [CAM_W-1:0]                  mask;
    logic [CNT_W-1:0]                  almostPt;
    logic [CTL_W-1:0]                  errCode;
    logic [CTL_W-1:0]                  irqEn;
    logic                              errFlag;
    logic                              initDone;
    logic                              buffered;
    logic [INIT_CNT_W-1:0]             initCnt;
    logic [3:0]                        matchCnt;
    logic                              hit;
    logic [OUT_W-1:0]                  outData;
    logic                              outValid;
    logic                              ackLow;
    logic                              rdOe;
    logic [CTL_W-1:0]                  rdData;
  } cme_dev_s;

  cme_dev_s         r_r;
  cme_dev_s         r_nxt;
  logic [CAM_W-1:0] key;
  logic             freeHit;
  logic [IDX_W-1:0] freeIdx;
  logic             delHit;
  logic [IDX_W-1:0] delIdx;
  logic             srchHit;
  logic [OUT_W-1:0] srchData;
  logic             opWr;
  logic             busy;
  logic [CTL_W-1:0] flags;

  // masked compare, set mask bits are don't-care
  function automatic logic keyHit(input logic [CAM_W-1:0] ent,
                                  input logic [CAM_W-1:0] word,
                                  input logic [CAM_W-1:0] msk);
    keyHit = ((ent ^ word) & ~msk) == '0;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // searches

  always_comb
  begin
    key      = {r_r.io[3], r_r.io[2], r_r.io[1], r_r.io[0]};
    freeHit  = 1'b0;
    freeIdx  = '0;
    delHit   = 1'b0;
    delIdx   = '0;
    srchHit  = 1'b0;
    srchData = '0;
    // descending loop so the lowest index wins
    for (int i = CAM_DEPTH - 1; i >= 0; i--)
    begin
      if (!r_r.vld[i])
      begin
        freeHit = 1'b1;
        freeIdx = IDX_W'(i);
      end
      if (r_r.vld[i] && keyHit(r_r.tbl[i], key, r_r.mask))
      begin
        delHit = 1'b1;
        delIdx = IDX_W'(i);
      end
      if (r_r.vld[i] && keyHit(r_r.tbl[i], link.matchBus, r_r.mask))
      begin
        srchHit  = 1'b1;
        srchData = r_r.tbl[i][OUT_W-1:0];
      end
    end
    // queued entries are matchable at once
    for (int j = QUEUE_DEPTH - 1; j >= 0; j--)
    begin
      if (QCNT_W'(j) < r_r.qCnt && keyHit(r_r.que[j], link.matchBus, r_r.mask))
      begin
        srchHit  = 1'b1;
        srchData = r_r.que[j][OUT_W-1:0];
      end
    end
  end

  assign busy  = r_r.initCnt != '0;
  assign opWr  = !link.ctlSelN && !r_r.ackLow && !link.ctlWeN && !busy;
  always_comb
  begin
    flags               = '0;
    flags[FLG_INIT]     = r_r.initDone;
    flags[FLG_BUF]      = r_r.buffered;
    flags[FLG_Q_EMPTY]  = r_r.qCnt == '0;
    flags[FLG_Q_FULL]   = r_r.qCnt == QCNT_W'(QUEUE_DEPTH);
    flags[FLG_TBL_FULL] = r_r.cnt == CNT_W'(CAM_DEPTH);
    flags[FLG_ERR]      = r_r.errFlag;
    flags[FLG_ALMOST]   = r_r.cnt >= r_r.almostPt;
    flags[FLG_DONE]     = !busy;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    r_nxt = r_r;
    if (clkEn)
    begin
      // control port handshake
      if (r_r.ackLow && link.ctlSelN)
      begin
        r_nxt.ackLow = 1'b0;
        r_nxt.rdOe   = 1'b0;
      end
      else if (!link.ctlSelN && !r_r.ackLow && link.ctlWeN)
      begin
        r_nxt.ackLow = 1'b1;
        r_nxt.rdOe   = 1'b1;
        case (link.ctlAddr)
          OFF_OP:   r_nxt.rdData = '0;
          OFF_FLAG: r_nxt.rdData = flags;
          OFF_ERR:  r_nxt.rdData = r_r.errCode;
          OFF_IRQ:  r_nxt.rdData = r_r.irqEn;
          default:  r_nxt.rdData = r_r.io[link.ctlAddr[1:0]];
        endcase
      end
      else if (opWr)
      begin
        r_nxt.ackLow = 1'b1;
        if (link.ctlAddr == OFF_IRQ)
          r_nxt.irqEn = link.ctlData;
        else if (link.ctlAddr < OFF_OP)
          r_nxt.io[link.ctlAddr[1:0]] = link.ctlData;
        else if (link.ctlAddr == OFF_OP)
        begin
          r_nxt.errFlag = 1'b0;
          r_nxt.errCode = ERR_NONE;
          case (link.ctlData)
            OP_INS_A, OP_INS_B:
              if (r_r.buffered)
              begin
                if (r_r.qCnt == QCNT_W'(QUEUE_DEPTH))
                begin
                  r_nxt.errFlag = 1'b1;
                  r_nxt.errCode = ERR_Q_FULL;
                end
                else
                begin
                  r_nxt.que[r_r.qCnt] = key;
                  r_nxt.qCnt          = r_r.qCnt + 1'b1;
                end
              end
              else if (!freeHit)
              begin
                r_nxt.errFlag = 1'b1;
                r_nxt.errCode = ERR_TBL_FULL;
              end
              else
              begin
                r_nxt.tbl[freeIdx] = key;
                r_nxt.vld[freeIdx] = 1'b1;
                r_nxt.cnt          = r_r.cnt + 1'b1;
                r_nxt.initDone     = 1'b0;
              end
            OP_DEL_A, OP_DEL_B:
              if (delHit)
              begin
                r_nxt.vld[delIdx] = 1'b0;
                r_nxt.cnt         = r_r.cnt - 1'b1;
              end
            OP_INIT:
            begin
              r_nxt.initCnt  = INIT_CNT_W'(INIT_CYCLES);
              r_nxt.initDone = 1'b0;
            end
            OP_FAST:
              if (r_r.qCnt != '0)
              begin
                r_nxt.errFlag = 1'b1;
                r_nxt.errCode = ERR_Q_WR;
              end
              else
                r_nxt.buffered = 1'b0;
            OP_BUF:             r_nxt.buffered = 1'b1;
            OP_MASK_A, OP_MASK_B: r_nxt.mask   = key;
            OP_ALMOST:          r_nxt.almostPt = r_r.io[0][CNT_W-1:0];
            OP_COUNT:           r_nxt.io[0]    = CTL_W'(r_r.cnt);
            default:
            begin
              r_nxt.errFlag = 1'b1;
              r_nxt.errCode = ERR_INVALID;
            end
          endcase
        end
      end
      // queue drains into the table between matches and control writes
      if (!opWr && r_r.qCnt != '0 && r_r.matchCnt == '0 && freeHit)
      begin
        r_nxt.tbl[freeIdx] = r_r.que[0];
        r_nxt.vld[freeIdx] = 1'b1;
        r_nxt.cnt          = r_r.cnt + 1'b1;
        r_nxt.que          = {CAM_W'(0), r_r.que[QUEUE_DEPTH-1:1]};
        r_nxt.qCnt         = r_r.qCnt - 1'b1;
      end
      // initialization timer
      if (busy)
      begin
        r_nxt.initCnt = r_r.initCnt - 1'b1;
        if (r_r.initCnt == INIT_CNT_W'(1))
          r_nxt.initDone = 1'b1;
      end
      // match engine; a strobe during a running match is ignored
      r_nxt.outValid = 1'b0;
      if (r_r.matchCnt != '0)
      begin
        r_nxt.matchCnt = r_r.matchCnt - 1'b1;
        r_nxt.outValid = r_r.matchCnt == 4'h1;
      end
      else if (link.matchRequestStrobe)
      begin
        r_nxt.matchCnt = 4'(MATCH_CYC);
        r_nxt.hit      = srchHit && r_r.initDone;
        r_nxt.outData  = srchData;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_r          <= '0;
      r_r.mask     <= MASK_RST;
      r_r.almostPt <= ALMOST_RST;
      r_r.errCode  <= ERR_NONE;
    end
    else
      r_r <= r_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.matchCompleteN = !r_r.outValid;
  assign link.matchSuccessN  = !(r_r.outValid && r_r.hit);
  assign link.mqDev          = r_r.outData;
  assign link.mqDevOe        = r_r.outValid && r_r.hit;
  assign link.ackOe          = r_r.ackLow;
  assign link.ctlDataDev     = r_r.rdData;
  assign link.ctlDataDevOe   = r_r.rdOe && !link.ctlSelN;
endmodule // cme_device

// [src/cme_host.sv]
// Purpose: host end: APB registers drive the control and match ports
// Assumes: software follows the set-up order and builds entries
// Notes:   pready always high, commands written while busy are dropped
`timescale 1ns/10ps
module cme_host
  import cme_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  cme_link_if.host         link
);
  import cme_pkg::*;

  typedef struct packed {
    cme_ctl_e          st;
    logic [31:0]       cmd;
    logic [CTL_W-1:0]  rdData;
    logic [CAM_W-1:0]  word;
    logic              pend;
    logic              strobe;
    logic              waitRes;
    logic [GAP_W-1:0]  gapCnt;
    logic              done;
    logic              hit;
    logic [OUT_W-1:0]  res;
    logic [31:0]       prd;
  } cme_host_s;

  cme_host_s r_r;
  cme_host_s r_nxt;
  logic      wrEn;
  logic      mapped;

  assign wrEn   = psel && penable && pwrite;
  assign mapped = paddr inside {H_CMD, H_STAT, H_RDAT, H_MLO, H_MHI, H_MGO, H_MRES};

  always_comb
  begin
    r_nxt = r_r;
    if (clkEn)
    begin
      // read data is latched in the setup cycle
      if (psel && !penable)
        case (paddr)
          H_CMD:   r_nxt.prd = r_r.cmd;
          H_STAT:  r_nxt.prd = {28'h0, r_r.hit, r_r.done, r_r.pend, r_r.st != C_IDLE};
          H_RDAT:  r_nxt.prd = {16'h0, r_r.rdData};
          H_MLO:   r_nxt.prd = r_r.word[31:0];
          H_MHI:   r_nxt.prd = r_r.word[63:32];
          H_MRES:  r_nxt.prd = r_r.res;
          default: r_nxt.prd = '0;
        endcase
      if (wrEn && paddr == H_MLO)
        r_nxt.word[31:0] = pwdata;
      if (wrEn && paddr == H_MHI)
        r_nxt.word[63:32] = pwdata;
      // control port: hold until acknowledged, then release
      case (r_r.st)
        C_IDLE:
          if (wrEn && paddr == H_CMD)
          begin
            r_nxt.cmd = pwdata;
            r_nxt.st  = C_SEL;
          end
        C_SEL:
          if (!link.transferAckN)
          begin
            r_nxt.rdData = link.ctlData;
            r_nxt.st     = C_REL;
          end
        C_REL:
          if (link.transferAckN)
            r_nxt.st = C_IDLE;
        default: r_nxt.st = C_IDLE;
      endcase
      // match requests
      r_nxt.strobe = 1'b0;
      if (r_r.gapCnt != '0)
        r_nxt.gapCnt = r_r.gapCnt - 1'b1;
      if (wrEn && paddr == H_MGO)
      begin
        r_nxt.pend = 1'b1;
        r_nxt.done = 1'b0;
      end
      else if (r_r.pend && !r_r.waitRes && r_r.gapCnt == '0 && !r_r.strobe)
      begin
        r_nxt.strobe  = 1'b1;
        r_nxt.pend    = 1'b0;
        r_nxt.waitRes = 1'b1;
        r_nxt.gapCnt  = GAP_W'(REQ_GAP_CYC);
      end
      if (r_r.waitRes && !link.matchCompleteN)
      begin
        r_nxt.waitRes = 1'b0;
        r_nxt.done    = 1'b1;
        r_nxt.hit     = !link.matchSuccessN;
        r_nxt.res     = link.matchBus[OUT_W-1:0];
        if (r_r.gapCnt < GAP_W'(IDLE_CYC + 1))
          r_nxt.gapCnt = GAP_W'(IDLE_CYC + 1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata                  = r_r.prd;
  assign pready                  = 1'b1;
  assign pslverr                 = psel && penable && !mapped;
  assign link.ctlAddr            = r_r.cmd[CMD_ADDR_LSB +: CTL_AW];
  assign link.ctlWeN             = !r_r.cmd[CMD_WE_BIT];
  assign link.ctlSelN            = r_r.st != C_SEL;
  assign link.ctlDataHost        = r_r.cmd[CTL_W-1:0];
  assign link.ctlDataHostOe      = r_r.st == C_SEL && r_r.cmd[CMD_WE_BIT];
  assign link.matchRequestStrobe = r_r.strobe;
  assign link.mqHost             = r_r.word;
  assign link.mqHostOe           = r_r.strobe;
endmodule // cme_host

// [src/cme_link_if.sv]
// Purpose: pins between the CAM engine and its host end
// Assumes: shared buses resolved here from output enables, idle level high
// Notes:   open-drain acknowledge modelled as a low pull with enable
`timescale 1ns/10ps
interface cme_link_if;
  import cme_pkg::*;
  logic [CTL_AW-1:0] ctlAddr;
  logic              ctlSelN;
  logic              ctlWeN;
  logic [CTL_W-1:0]  ctlDataHost;
  logic              ctlDataHostOe;
  logic [CTL_W-1:0]  ctlDataDev;
  logic              ctlDataDevOe;
  logic              ackOe;
  logic              transferAckN;
  logic [CTL_W-1:0]  ctlData;
  logic              matchRequestStrobe;
  logic [CAM_W-1:0]  mqHost;
  logic              mqHostOe;
  logic [OUT_W-1:0]  mqDev;
  logic              mqDevOe;
  logic [CAM_W-1:0]  matchBus;
  logic              matchCompleteN;
  logic              matchSuccessN;

  assign transferAckN = ~ackOe;
  assign ctlData  = ctlDataDevOe ? ctlDataDev : (ctlDataHostOe ? ctlDataHost : 16'hFFFF);
  assign matchBus = mqHostOe ? mqHost
                  : {32'hFFFF_FFFF, (mqDevOe ? mqDev : 32'hFFFF_FFFF)};

  modport dev (input ctlAddr, ctlSelN, ctlWeN, ctlData, matchRequestStrobe, matchBus,
               output ctlDataDev, ctlDataDevOe, ackOe, mqDev, mqDevOe,
               matchCompleteN, matchSuccessN);
  modport host (input transferAckN, ctlData, matchBus, matchCompleteN, matchSuccessN,
                output ctlAddr, ctlSelN, ctlWeN, ctlDataHost, ctlDataHostOe,
                matchRequestStrobe, mqHost, mqHostOe);
endinterface

// [src/cme_pkg.sv]
// Purpose: shared constants and types for the CAM match/entry engine and its host end
// Assumes: 50 MHz interface clock
// Notes:   control port offsets are register indexes on a 3-bit address
package cme_pkg;
  // table geometry
  localparam int CAM_DEPTH   = 4096;
  localparam int CAM_W       = 64;
  localparam int IDX_W       = 12;
  localparam int CNT_W       = 13;
  localparam int OUT_W       = 32;
  localparam int CTL_W       = 16;
  localparam int CTL_AW      = 3;
  localparam int QUEUE_DEPTH = 12;
  localparam int QCNT_W      = 4;
  localparam int INIT_CNT_W  = 20;
  localparam int GAP_W       = 4;

  // control port register indexes
  localparam logic [CTL_AW-1:0] OFF_IO0  = 3'h0;
  localparam logic [CTL_AW-1:0] OFF_OP   = 3'h4;
  localparam logic [CTL_AW-1:0] OFF_FLAG = 3'h5;
  localparam logic [CTL_AW-1:0] OFF_ERR  = 3'h6;
  localparam logic [CTL_AW-1:0] OFF_IRQ  = 3'h7;

  // operation codes
  localparam logic [CTL_W-1:0] OP_INS_A   = 16'h0000;
  localparam logic [CTL_W-1:0] OP_INS_B   = 16'h000F;
  localparam logic [CTL_W-1:0] OP_DEL_A   = 16'h0001;
  localparam logic [CTL_W-1:0] OP_DEL_B   = 16'h000E;
  localparam logic [CTL_W-1:0] OP_MASK_A  = 16'h0002;
  localparam logic [CTL_W-1:0] OP_MASK_B  = 16'h000D;
  localparam logic [CTL_W-1:0] OP_COUNT   = 16'h0003;
  localparam logic [CTL_W-1:0] OP_FAST    = 16'h0004;
  localparam logic [CTL_W-1:0] OP_BUF     = 16'h0005;
  localparam logic [CTL_W-1:0] OP_ALMOST  = 16'h0007;
  localparam logic [CTL_W-1:0] OP_INIT    = 16'h000B;

  // error codes
  localparam logic [CTL_W-1:0] ERR_NONE     = 16'hFFFF;
  localparam logic [CTL_W-1:0] ERR_INVALID  = 16'hFFFD;
  localparam logic [CTL_W-1:0] ERR_Q_RD     = 16'hFFFC;
  localparam logic [CTL_W-1:0] ERR_NO_INIT  = 16'hFFFB;
  localparam logic [CTL_W-1:0] ERR_Q_WR     = 16'hFFFA;
  localparam logic [CTL_W-1:0] ERR_TBL_FULL = 16'hFFF9;
  localparam logic [CTL_W-1:0] ERR_Q_FULL   = 16'hFFF8;

  // flag register bit positions
  localparam int FLG_INIT     = 2;
  localparam int FLG_BUF      = 3;
  localparam int FLG_Q_EMPTY  = 4;
  localparam int FLG_Q_FULL   = 5;
  localparam int FLG_TBL_FULL = 6;
  localparam int FLG_ERR      = 7;
  localparam int FLG_ALMOST   = 8;
  localparam int FLG_DONE     = 10;

  // reset values
  localparam logic [CAM_W-1:0] MASK_RST   = 64'h0000_0000_0000_0000;
  localparam logic [CNT_W-1:0] ALMOST_RST = 13'h1000;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MATCH_TIME_NS = 160;
  localparam int MATCH_CYC     = MATCH_TIME_NS / CLK_PERIOD_NS;
  localparam int INIT_TIME_MS  = 12;
  localparam int INIT_CYC      = INIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int IDLE_TIME_NS  = 40;
  localparam int IDLE_CYC      = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REQ_GAP_CYC   = 10;

  // host-side APB map (byte addresses)
  localparam logic [7:0] H_CMD   = 8'h00;
  localparam logic [7:0] H_STAT  = 8'h04;
  localparam logic [7:0] H_RDAT  = 8'h08;
  localparam logic [7:0] H_MLO   = 8'h0C;
  localparam logic [7:0] H_MHI   = 8'h10;
  localparam logic [7:0] H_MGO   = 8'h14;
  localparam logic [7:0] H_MRES  = 8'h18;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_WE_BIT   = 19;
  localparam int ST_BUSY      = 0;
  localparam int ST_PEND      = 1;
  localparam int ST_DONE      = 2;
  localparam int ST_HIT       = 3;

  typedef enum logic [1:0] {C_IDLE, C_SEL, C_REL} cme_ctl_e;
endpackage

// [tb/cme_link_monitor.sv]
// Purpose: link checks between the CAM engine and its host end
// Assumes: one clock domain, host spaces match strobes
// Notes:   sees resolved buses plus the device-side mqDev, mqDevOe and ctlDataDevOe drives
`timescale 1ns/10ps
module cme_link_monitor
(
  // clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst_b,
  // control port
  input wire logic                      ctlSelN,
  input wire logic                      ctlWeN,
  input wire logic                      transferAckN,
  input wire logic                      ctlDataDevOe,
  // match port
  input wire logic                      matchRequestStrobe,
  input wire logic [cme_pkg::OUT_W-1:0] mqDev,
  input wire logic                      mqDevOe,
  input wire logic [cme_pkg::CAM_W-1:0] matchBus,
  input wire logic                      matchCompleteN,
  input wire logic                      matchSuccessN
);
  import cme_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // strobe sampled at the take edge, answer registered 8 edges later, seen at the 9th
  chk_done_after_take:
    assert property (matchRequestStrobe |-> ##9 !matchCompleteN) else $error("no completion");
  chk_done_has_cause:
    assert property ($fell(matchCompleteN) |-> $past(matchRequestStrobe, 9))
    else $error("completion without request");
  chk_done_one_cycle:
    assert property (!matchCompleteN |=> matchCompleteN) else $error("completion too long");
  chk_hit_drives_bus:
    assert property (!matchSuccessN |-> mqDevOe && !matchCompleteN) else $error("hit not driven");
  chk_miss_leaves_bus:
    assert property (mqDevOe |-> !matchSuccessN) else $error("bus driven on miss");
  chk_hit_low_word:
    assert property (!matchSuccessN |-> matchBus[31:0] == mqDev) else $error("hit word lost");
  chk_read_ack_fast:
    assert property (!ctlSelN && ctlWeN && transferAckN |=> !transferAckN)
    else $error("read not acknowledged");
  chk_ack_release:
    assert property ($rose(ctlSelN) |=> transferAckN) else $error("ack not released");
  chk_read_oe_window:
    assert property (ctlDataDevOe |-> !ctlSelN && !transferAckN) else $error("data drive late");
endmodule // cme_link_monitor

// [tb/test_cam_match_and_entry_engine.sv]
// Purpose: APB-driven check of host and CAM engine joined by the link
// Assumes: init time shortened to 60 cycles
// Notes:   reference table kept in a queue, first match wins
`timescale 1ns/10ps
module test_cam_match_and_entry_engine;
  import cme_pkg::*;
  logic        clk_sys, rst_b, clkEn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] r;
  logic [63:0] ents[$];
  logic [63:0] msk, v;
  logic        e;
  bit          initd;
  int          mismatches, samplesChecked, n;
  logic [15:0] badOps[4] = '{16'h0006, 16'h0008, 16'h0009, 16'h000A};

  cme_link_if lnk();
  cme_device #(.INIT_CYCLES(60)) cme_device_i(.clk_sys(clk_sys), .rst_b(rst_b),
    .clkEn(clkEn), .link(lnk));
  cme_host cme_host_i(.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(lnk));
  cme_link_monitor cme_link_monitor_i(.clk_sys(clk_sys), .rst_b(rst_b),
    .ctlSelN(lnk.ctlSelN), .ctlWeN(lnk.ctlWeN), .transferAckN(lnk.transferAckN),
    .ctlDataDevOe(lnk.ctlDataDevOe), .matchRequestStrobe(lnk.matchRequestStrobe),
    .mqDev(lnk.mqDev), .mqDevOe(lnk.mqDevOe), .matchBus(lnk.matchBus),
    .matchCompleteN(lnk.matchCompleteN), .matchSuccessN(lnk.matchSuccessN));

  always #10 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // commands written while busy are dropped, so wait for idle each time
  task automatic ctl(input logic w, input logic [2:0] a, input logic [15:0] d);
    apb(H_CMD, 1'b1, {12'h000, w, a, d});
    q = 32'h1;
    for (n = 0; n < 500 && q[ST_BUSY] !== 1'b0; n++) apb(H_STAT, 1'b0, 32'h0);
    if (q[ST_BUSY] !== 1'b0) mismatches++;
    apb(H_RDAT, 1'b0, 32'h0);
    r = q[15:0];
  endtask

  task automatic put(input logic [63:0] val, input logic [15:0] opc);
    for (int i = 0; i < 4; i++) ctl(1'b1, 3'(i), val[16*i +: 16]);
    ctl(1'b1, OFF_OP, opc);
  endtask

  function automatic int findEnt(input logic [63:0] w);
    foreach (ents[i]) if (((ents[i] ^ w) & ~msk) == 64'h0) return i;
    return -1;
  endfunction

  task automatic doMatch(input logic [63:0] w);
    int k;
    apb(H_MLO, 1'b1, w[31:0]);
    apb(H_MHI, 1'b1, w[63:32]);
    apb(H_MGO, 1'b1, 32'h0);
    q = 32'h0;
    for (n = 0; n < 200 && q[ST_DONE] !== 1'b1; n++) apb(H_STAT, 1'b0, 32'h0);
    if (q[ST_DONE] !== 1'b1) mismatches++;
    k = initd ? findEnt(w) : -1;
    chk("hit", {31'h0, q[ST_HIT]}, {31'h0, k >= 0});
    apb(H_MRES, 1'b0, 32'h0);
    if (k >= 0)
      chk("result", q, ents[k][31:0]);
    else
      chk("missBus", q, 32'hFFFF_FFFF);
  endtask

  task automatic doInit();
    ctl(1'b1, OFF_OP, OP_INIT);
    // a write issued early must be held back until the timer has run out
    ctl(1'b1, OFF_IRQ, 16'h0000);
    ctl(1'b0, OFF_FLAG, 16'h0);
    chk("writeHeld", {31'h0, r[FLG_INIT]}, 32'h1);
    r = 16'h0;
    for (int i = 0; i < 100 && r[FLG_INIT] !== 1'b1; i++) ctl(1'b0, OFF_FLAG, 16'h0);
    chk("initFlag", {31'h0, r[FLG_INIT]}, 32'h1);
    initd = 1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    {clk_sys, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    clkEn = 1'b1;
    void'($urandom(51));
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(8'h1C, 1'b0, 32'h0);
    chk("pslverr", {31'h0, e}, 32'h1);
    ctl(1'b0, OFF_ERR, 16'h0);
    chk("errReset", {16'h0, r}, {16'h0, ERR_NONE});
    $display("test reset done");
    // match on the high word only
    msk = 64'h0000_0000_FFFF_FFFF;
    put(msk, OP_MASK_B);
    ctl(1'b1, OFF_OP, OP_FAST);
    for (int i = 0; i < 4; i++)
    begin
      v = {4'(i), 28'($urandom), 32'($urandom)};
      put(v, i[0] ? OP_INS_B : OP_INS_A);
      ents.push_back(v);
    end
    doMatch(ents[0]);
    doInit();
    foreach (ents[i]) doMatch({ents[i][63:32], 32'($urandom)});
    doMatch({4'hF, 28'($urandom), 32'($urandom)});
    $display("test fast load done");
    v = ents[1];
    put({v[63:32], 32'($urandom)}, OP_DEL_B);
    ents.delete(1);
    doMatch(v);
    ctl(1'b1, OFF_OP, OP_BUF);
    ctl(1'b0, OFF_FLAG, 16'h0);
    chk("bufFlag", {31'h0, r[FLG_BUF]}, 32'h1);
    v = {4'h8, 28'($urandom), 32'($urandom)};
    put(v, OP_INS_A);
    ents.push_back(v);
    doMatch(v);
    ctl(1'b1, OFF_OP, OP_COUNT);
    ctl(1'b0, OFF_IO0, 16'h0);
    chk("count", {16'h0, r}, ents.size());
    put(64'h1, OP_ALMOST);
    ctl(1'b0, OFF_FLAG, 16'h0);
    chk("almost", {31'h0, r[FLG_ALMOST]}, 32'h1);
    $display("test buffered done");
    foreach (badOps[i])
    begin
      ctl(1'b1, OFF_OP, badOps[i]);
      ctl(1'b0, OFF_ERR, 16'h0);
      chk("errCode", {16'h0, r}, {16'h0, ERR_INVALID});
      ctl(1'b0, OFF_FLAG, 16'h0);
      chk("errFlag", {31'h0, r[FLG_ERR]}, 32'h1);
      ctl(1'b1, OFF_OP, OP_BUF);
      ctl(1'b0, OFF_ERR, 16'h0);
      chk("errClear", {16'h0, r}, {16'h0, ERR_NONE});
      ctl(1'b0, OFF_FLAG, 16'h0);
      chk("flagClear", {31'h0, r[FLG_ERR]}, 32'h0);
    end
    $display("test errors done");
    ctl(1'b1, OFF_OP, OP_FAST);
    v = {4'h9, 28'($urandom), 32'($urandom)};
    put(v, OP_INS_B);
    ents.push_back(v);
    initd = 0;
    doMatch(ents[0]);
    doInit();
    doMatch(v);
    $display("test reinit done");
    print_verdict();
  end
endmodule // test_cam_match_and_entry_engine
